// [pkg/rxp_pkg.sv]
`default_nettype none

package rxp_pkg;

    // ------------------------------------------------------------------
    // stream geometry
    // ------------------------------------------------------------------
    localparam int LANE_W = 128;
    localparam int IN_LANES = 3;
    localparam int OUT_LANES = 4;
    localparam int CNT_W = 2;
    localparam int TOT_W = 3;

    // ------------------------------------------------------------------
    // thresholds and reset values
    // ------------------------------------------------------------------
    localparam logic [TOT_W-1:0] FULL_TOTAL = 3'h4;
    localparam logic [CNT_W-1:0] LEFT_RST = 2'h0;
    localparam logic EXTRA_RST = 1'b0;
    localparam logic VALID_RST = 1'b0;

    // mac user clock in this configuration, in kHz
    localparam int MAC_CLK_KHZ = 390625;

endpackage : rxp_pkg

`default_nettype wire

// [rtl/rxp_lane_count.sv]
`timescale 1ns/100ps
`default_nettype none

module rxp_lane_count #(
    parameter int LANE_W = rxp_pkg::LANE_W,
    parameter int IN_LANES = rxp_pkg::IN_LANES
) (
    input wire logic [IN_LANES*LANE_W/8-1:0] keep_i,
    output logic [rxp_pkg::CNT_W-1:0] count_o
);

    localparam int KB = LANE_W / 8;

    if (LANE_W < 8 || LANE_W % 8 != 0) begin : g_bad_lane
        $error("lane width must be a whole number of bytes");
    end
    if (IN_LANES < 1 || IN_LANES >= 2 ** rxp_pkg::CNT_W) begin : g_bad_n
        $error("lane count does not fit the count output");
    end

    logic [IN_LANES-1:0] lane_used;

    // ------------------------------------------------------------------
    // one flag per lane: its lowest byte is kept
    // ------------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < IN_LANES; g++) begin : g_lane
            assign lane_used[g] = keep_i[g*KB];
        end
    endgenerate

    // keep is contiguous from byte 0, so a plain sum gives the lane count
    always_comb begin
        count_o = '0;
        for (int i = 0; i < IN_LANES; i++) begin
            count_o = count_o + rxp_pkg::CNT_W'(lane_used[i]);
        end
        // a valid beat always carries at least one lane
        if (count_o == '0) begin
            count_o = rxp_pkg::CNT_W'(1);
        end
    end

endmodule : rxp_lane_count

`default_nettype wire

// [rtl/rxp_packer.sv]
`timescale 1ns/100ps
`default_nettype none


module rxp_packer #(
    parameter int LANE_W = rxp_pkg::LANE_W
) (
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic [rxp_pkg::IN_LANES*LANE_W-1:0] rx_data_i,
    input wire logic [rxp_pkg::IN_LANES*LANE_W/8-1:0] rx_keep_i,
    input wire logic rx_valid_i,
    input wire logic rx_last_i,
    output logic [rxp_pkg::OUT_LANES*LANE_W-1:0] user_out_word_o,
    output logic [rxp_pkg::OUT_LANES*LANE_W/8-1:0] user_out_byte_keep_o,
    output logic user_out_valid_o,
    output logic user_out_last_o
);

    localparam int IN_W = rxp_pkg::IN_LANES * LANE_W;
    localparam int OUT_W = rxp_pkg::OUT_LANES * LANE_W;
    localparam int IN_K = IN_W / 8;
    localparam int OUT_K = OUT_W / 8;
    localparam int CNT_W = rxp_pkg::CNT_W;
    localparam int TOT_W = rxp_pkg::TOT_W;

    // ------------------------------------------------------------------
    // elaboration checks
    // ------------------------------------------------------------------
    if (LANE_W < 8 || LANE_W % 8 != 0) begin : g_bad_lane
        $error("lane width must be a whole number of bytes");
    end
    if (rxp_pkg::OUT_LANES != rxp_pkg::IN_LANES + 1) begin : g_bad_ratio
        $error("packer serves only one more output lane than input lanes");
    end
    if (rxp_pkg::IN_LANES >= (1 << CNT_W)) begin : g_bad_count
        $error("leftover counter too narrow for the input lanes");
    end
    if (2 * rxp_pkg::IN_LANES >= (1 << TOT_W)) begin : g_bad_total
        $error("total counter too narrow for latch plus beat");
    end

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    logic [CNT_W-1:0] leftover_lane_count;
    logic [IN_W-1:0] leftover_lane_latch;
    logic [IN_K-1:0] leftover_keep;
    logic extra_last_flag;

    logic [CNT_W-1:0] incoming_lane_count;
    logic [TOT_W-1:0] total_lane_count;
    logic [2*IN_W-1:0] merged_data;
    logic [2*IN_K-1:0] merged_keep;

    logic emit;
    logic next_last;
    logic [OUT_W-1:0] next_word;
    logic [OUT_K-1:0] next_keep;
    logic [CNT_W-1:0] next_left;
    logic [IN_W-1:0] next_latch;
    logic [IN_K-1:0] next_latch_keep;
    logic next_extra;

    localparam int KB = LANE_W / 8;
    logic [rxp_pkg::IN_LANES-1:0] lane_live;
    logic [IN_W-1:0] beat_data;
    logic [IN_K-1:0] beat_keep;

    // what this cycle does with the latch and the output word
    typedef enum logic [2:0] {
        OP_IDLE = 3'h0,
        OP_FILL = 3'h1,
        OP_WORD = 3'h3,
        OP_SPLIT = 3'h2,
        OP_SHORT = 3'h6,
        OP_FLUSH = 3'h7,
        OP_FLUSH_LOAD = 3'h5
    } rxp_op_t;
    rxp_op_t op;

    // ------------------------------------------------------------------
    // lane counting
    // ------------------------------------------------------------------
    rxp_lane_count #(
        .LANE_W(LANE_W),
        .IN_LANES(rxp_pkg::IN_LANES)
    ) u_lane_count (
        .keep_i(rx_keep_i),
        .count_o(incoming_lane_count)
    );

    // ------------------------------------------------------------------
    // lane mask
    // ------------------------------------------------------------------
    // lanes above the beat's count are cleared; the merge below relies on
    // the latch holding zero above its leftover count
    genvar g;
    generate
        for (g = 0; g < rxp_pkg::IN_LANES; g++) begin : g_mask
            assign lane_live[g] = CNT_W'(g) < incoming_lane_count;
            assign beat_data[g*LANE_W +: LANE_W] =
                rx_data_i[g*LANE_W +: LANE_W] & {LANE_W{lane_live[g]}};
            assign beat_keep[g*KB +: KB] =
                rx_keep_i[g*KB +: KB] & {KB{lane_live[g]}};
        end
    endgenerate

    assign total_lane_count = TOT_W'(incoming_lane_count)
        + TOT_W'(leftover_lane_count);

    // ------------------------------------------------------------------
    // lane merge
    // ------------------------------------------------------------------
    // lanes of the latch above the leftover count are held at zero, so a
    // plain or after shifting the new beat up places old lanes first
    always_comb begin
        merged_data = {{IN_W{1'b0}}, leftover_lane_latch}
            | ({{IN_W{1'b0}}, beat_data}
            << (int'(leftover_lane_count) * LANE_W));
        merged_keep = {{IN_K{1'b0}}, leftover_keep}
            | ({{IN_K{1'b0}}, beat_keep}
            << (int'(leftover_lane_count) * (LANE_W / 8)));
    end

    // ------------------------------------------------------------------
    // cycle decode
    // ------------------------------------------------------------------
    // a pending flush always goes out first; a beat in that cycle only
    // lands in the latch
    always_comb begin
        op = OP_IDLE;
        if (extra_last_flag && rx_valid_i) begin
            op = OP_FLUSH_LOAD;
        end else if (extra_last_flag) begin
            op = OP_FLUSH;
        end else if (rx_valid_i && rx_last_i) begin
            if (total_lane_count > rxp_pkg::FULL_TOTAL) begin
                op = OP_SPLIT;
            end else begin
                op = OP_SHORT;
            end
        end else if (rx_valid_i) begin
            if (total_lane_count >= rxp_pkg::FULL_TOTAL) begin
                op = OP_WORD;
            end else begin
                op = OP_FILL;
            end
        end
    end

    // ------------------------------------------------------------------
    // output word selection
    // ------------------------------------------------------------------
    always_comb begin
        emit = 1'b0;
        next_last = 1'b0;
        next_word = merged_data[OUT_W-1:0];
        next_keep = {OUT_K{1'b1}};
        case (op)
            OP_WORD, OP_SPLIT: begin
                emit = 1'b1;
            end
            OP_SHORT: begin
                emit = 1'b1;
                next_last = 1'b1;
                next_keep = merged_keep[OUT_K-1:0];
            end
            OP_FLUSH, OP_FLUSH_LOAD: begin
                // the tail that did not fit the previous word
                emit = 1'b1;
                next_last = 1'b1;
                next_word = {{(OUT_W-IN_W){1'b0}}, leftover_lane_latch};
                next_keep = {{(OUT_K-IN_K){1'b0}}, leftover_keep};
            end
            default: begin
                emit = 1'b0;
            end
        endcase
    end

    // ------------------------------------------------------------------
    // latch and counter next values
    // ------------------------------------------------------------------
    always_comb begin
        next_left = leftover_lane_count;
        next_latch = leftover_lane_latch;
        next_latch_keep = leftover_keep;
        case (op)
            OP_FILL: begin
                // an empty latch takes the whole beat, else it grows
                next_left = total_lane_count[CNT_W-1:0];
                next_latch = merged_data[IN_W-1:0];
                next_latch_keep = merged_keep[IN_K-1:0];
            end
            OP_WORD, OP_SPLIT: begin
                next_left = CNT_W'(total_lane_count
                    - rxp_pkg::FULL_TOTAL);
                next_latch = {{(OUT_W-IN_W){1'b0}},
                    merged_data[2*IN_W-1:OUT_W]};
                next_latch_keep = {{(OUT_K-IN_K){1'b0}},
                    merged_keep[2*IN_K-1:OUT_K]};
            end
            OP_FLUSH_LOAD: begin
                next_left = incoming_lane_count;
                next_latch = beat_data;
                next_latch_keep = beat_keep;
            end
            OP_SHORT, OP_FLUSH: begin
                next_left = rxp_pkg::LEFT_RST;
                next_latch = '0;
                next_latch_keep = '0;
            end
            default: begin
                next_left = leftover_lane_count;
            end
        endcase
    end

    // ------------------------------------------------------------------
    // extra-last flag next value
    // ------------------------------------------------------------------
    always_comb begin
        case (op)
            OP_SPLIT: next_extra = 1'b1;
            // a one-beat packet caught in the flush goes out as the next
            OP_FLUSH_LOAD: next_extra = rx_last_i;
            OP_FLUSH: next_extra = 1'b0;
            default: next_extra = extra_last_flag;
        endcase
    end

    // ------------------------------------------------------------------
    // latch and counters, on the mac user clock
    // ------------------------------------------------------------------
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            leftover_lane_count <= rxp_pkg::LEFT_RST;
            extra_last_flag <= rxp_pkg::EXTRA_RST;
        end else begin
            leftover_lane_count <= next_left;
            extra_last_flag <= next_extra;
        end
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            leftover_lane_latch <= '0;
            leftover_keep <= '0;
        end else begin
            leftover_lane_latch <= next_latch;
            leftover_keep <= next_latch_keep;
        end
    end

    // ------------------------------------------------------------------
    // output word
    // ------------------------------------------------------------------
    // no ready exists on either side; a word the engine cannot take is
    // lost, which is why the engine must always accept
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            user_out_valid_o <= rxp_pkg::VALID_RST;
            user_out_last_o <= 1'b0;
        end else begin
            user_out_valid_o <= emit;
            user_out_last_o <= emit & next_last;
        end
    end

    // data is only meaningful with valid, so it simply holds otherwise
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            user_out_word_o <= '0;
            user_out_byte_keep_o <= '0;
        end else if (emit) begin
            user_out_word_o <= next_word;
            user_out_byte_keep_o <= next_keep;
        end
    end

endmodule : rxp_packer

`default_nettype wire

// [tb/rxp_packer_bench.sv]
`timescale 1ns/100ps
`default_nettype none

module rxp_packer_bench;
    // narrow lanes keep the run light; two keep bits each
    localparam int LW = 16;
    localparam int KW = LW/8;
    localparam int OL = rxp_pkg::OUT_LANES;
    localparam int OW = OL*LW+OL*KW+1;
    localparam logic [3*KW-1:0] KMAX = '1;
    logic clk_i = 1'b0;
    logic reset_n_i = 1'b0;
    logic [3*LW-1:0] rx_data_i = '0;
    logic [3*KW-1:0] rx_keep_i = '0;
    logic rx_valid_i = 1'b0;
    logic rx_last_i = 1'b0;
    logic [OL*LW-1:0] word;
    logic [OL*KW-1:0] keep;
    logic valid;
    logic last;
    logic [31:0] seed = 32'hc59c;
    logic [LW+KW-1:0] lanes[$];
    logic [OW-1:0] exp_q[$];
    int bad_count = 0;
    int cmp_count = 0;
    int pkts = 0;
    int got_pkts;

    always #25 clk_i = ~clk_i;

    rxp_packer #(.LANE_W(LW)) i_dut (.clk_i(clk_i), .reset_n_i(reset_n_i),
        .rx_data_i(rx_data_i), .rx_keep_i(rx_keep_i), .rx_valid_i(rx_valid_i),
        .rx_last_i(rx_last_i), .user_out_word_o(word),
        .user_out_byte_keep_o(keep), .user_out_valid_o(valid),
        .user_out_last_o(last));
    rxp_sink i_sink (.clk_i(clk_i), .reset_n_i(reset_n_i), .valid_i(valid),
        .last_i(last), .pkts_o(got_pkts));

    // ------------------------------------------------------------------
    // reference and checking
    // ------------------------------------------------------------------
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction : xs

    task automatic check(input logic [OW-1:0] seen, input logic [OW-1:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("unexpected at %0t: got %h want %h", $time, seen, exp);
        end
    endtask : check

    task automatic emit(input int n, input logic fin);
        logic [OW-1:0] e;
        e = '0;
        for (int i = 0; i < n; i++) begin
            e[i*LW +: LW] = lanes[0][LW-1:0];
            e[OL*LW+i*KW +: KW] = lanes[0][LW+KW-1:LW];
            void'(lanes.pop_front());
        end
        if (!fin) e[OL*LW +: OL*KW] = '1;
        e[OW-1] = fin;
        exp_q.push_back(e);
    endtask : emit

    task automatic beat(input logic lst, input int nb);
        logic [3*LW-1:0] d;
        logic [3*KW-1:0] k;
        seed = xs(seed);
        d = {seed, seed[31:16]};
        k = KMAX >> (3*KW-nb);
        for (int i = 0; i < (nb+KW-1)/KW; i++) lanes.push_back({k[i*KW +: KW],
            d[i*LW +: LW]});
        while (lanes.size() > 4 || (lanes.size() == 4 && !lst)) emit(4, 1'b0);
        if (lst) emit(lanes.size(), 1'b1);
        rx_data_i <= d;
        rx_keep_i <= k;
        rx_valid_i <= 1'b1;
        rx_last_i <= lst;
        @(posedge clk_i);
        if (seed[1:0] == 2'h0) begin
            rx_valid_i <= 1'b0;
            rx_last_i <= seed[2];
            repeat (1 + seed[3]) @(posedge clk_i);
        end
    endtask : beat

    logic [OW-1:0] want;
    always @(posedge clk_i) begin
        if (reset_n_i && valid) begin
            want = exp_q.size() ? exp_q.pop_front() : 'x;
            check({last, keep, word}, want);
        end
    end

    task automatic wrap_up;
        $display("bad_count %0d cmp_count %0d", bad_count, cmp_count);
        if (bad_count == 0 && cmp_count > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : wrap_up

    initial begin
        #(50*20000);
        bad_count++;
        wrap_up();
    end

    initial begin
        int nbeats;
        int tail;
        repeat (20) @(posedge clk_i);
        reset_n_i <= 1'b1;
        for (int p = 0; p < 80; p++) begin
            seed = xs(seed);
            // packet shape is fixed here; beat() moves the seed on
            nbeats = seed[1:0];
            tail = 1 + seed[8:4] % 6;
            for (int b = 0; b <= nbeats; b++)
                beat(b == nbeats, b == nbeats ? tail : 6);
            pkts++;
        end
        rx_valid_i <= 1'b0;
        repeat (6) @(posedge clk_i);
        check(OW'(exp_q.size()), '0);
        check(OW'(got_pkts), OW'(pkts));
        wrap_up();
    end
endmodule : rxp_packer_bench

`default_nettype wire

// [tb/rxp_packer_chk.sv]
`timescale 1ns/100ps
`default_nettype none

module rxp_packer_chk #(
    parameter int LANE_W = rxp_pkg::LANE_W
) (
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic [rxp_pkg::IN_LANES*LANE_W-1:0] rx_data_i,
    input wire logic [rxp_pkg::IN_LANES*LANE_W/8-1:0] rx_keep_i,
    input wire logic rx_valid_i,
    input wire logic rx_last_i,
    input wire logic [rxp_pkg::OUT_LANES*LANE_W-1:0] user_out_word_o,
    input wire logic [rxp_pkg::OUT_LANES*LANE_W/8-1:0] user_out_byte_keep_o,
    input wire logic user_out_valid_o,
    input wire logic user_out_last_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);
    logic fed_last;
    // a last beat taken on the previous edge may owe a flush word
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) fed_last <= 1'b0;
        else fed_last <= rx_valid_i && rx_last_i;
    end
    AST_RESET_CLEAR: assert property ($rose(reset_n_i) |->
        !user_out_valid_o && !user_out_last_o) else $error("out after reset");
    AST_PAUSE_DROP: assert property (!rx_valid_i && !fed_last |=>
        !user_out_valid_o) else $error("valid kept in pause");
    AST_NO_OUT_UNFED: assert property (user_out_valid_o |->
        $past(rx_valid_i) || user_out_last_o) else $error("word from nothing");
    AST_LAST_HAS_VALID: assert property (user_out_last_o |->
        user_out_valid_o) else $error("last without valid");
    AST_NONFINAL_KEEP: assert property (user_out_valid_o &&
        !user_out_last_o |-> &user_out_byte_keep_o) else $error("short keep");
    AST_FINAL_KEEP: assert property (user_out_last_o |->
        user_out_byte_keep_o[0] && ((user_out_byte_keep_o + 1'b1) &
        user_out_byte_keep_o) == '0) else $error("final keep not packed");
    AST_LAST_SOON: assert property (rx_valid_i && rx_last_i |=>
        ##[0:1] user_out_valid_o && user_out_last_o) else $error("late last");
    AST_FLUSH: assert property (user_out_valid_o && !user_out_last_o &&
        fed_last |=> user_out_valid_o && user_out_last_o) else $error("flush");
    AST_WORD_HOLD: assert property (!user_out_valid_o |->
        $stable(user_out_word_o) && $stable(user_out_byte_keep_o))
        else $error("word moved while idle");
    cover property (user_out_valid_o && !user_out_last_o ##1 user_out_last_o);
    cover property (rx_valid_i && rx_last_i ##1 rx_valid_i);
    cover property (!rx_valid_i ##1 !rx_valid_i);
endmodule : rxp_packer_chk

bind rxp_packer rxp_packer_chk #(.LANE_W(LANE_W)) u_chk (
    .clk_i(clk_i), .reset_n_i(reset_n_i), .rx_data_i(rx_data_i),
    .rx_keep_i(rx_keep_i), .rx_valid_i(rx_valid_i), .rx_last_i(rx_last_i),
    .user_out_word_o(user_out_word_o),
    .user_out_byte_keep_o(user_out_byte_keep_o),
    .user_out_valid_o(user_out_valid_o), .user_out_last_o(user_out_last_o));

`default_nettype wire

// [tb/rxp_sink.sv]
`timescale 1ns/100ps
`default_nettype none

module rxp_sink (
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic valid_i,
    input wire logic last_i,
    output int pkts_o
);
    // offload engine end: takes every word at once, no stall
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) pkts_o <= 0;
        else if (valid_i && last_i) pkts_o <= pkts_o + 1;
    end
endmodule : rxp_sink

`default_nettype wire
